/* logic/fsws_top.v */
// flash self-write sequencer: registers, unlock, stall and programming control
//
// How it works
// - stall core during write; clocks keep running
// - stall after second no-op slot, resume at write end
// - write permit clear blocks all writes
// - start accepted only if armed earlier
// - disarming mid-cycle does not abort write
// - completion clears start, sets done flag
// - no automatic read-back after writing
// - power-up clears arm, timer blocks writes
// - data memory access ignores data protect
// - protect with data protect clear kills serial port
// - protect bits never block internal reads
// - protection clears by full erase or reset
// - select bit frozen while operation runs
// - start bit only settable; hardware clears
// - master or watchdog reset mid-write sets abort flag
`timescale 1ns/1ps
`include "fsws_defines.vh"
module fsws_top
#(
   parameter ADDR_WIDTH = 13,
   parameter WRITE_CYCLES = `FSWS_WRITE_CYCLES,
   parameter PWRUP_CYCLES = `FSWS_PWRUP_CYCLES
)
(
   // clock, reset, enable
   input wire clock_i,
   input wire reset_i,
   input wire clock_enable_i,
   // register port
   input wire [3:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_write_i,
   input wire reg_read_i,
   output reg [7:0] reg_rdata_o,
   // reset cause and configuration pins
   input wire power_on_i,
   input wire abort_reset_i,
   input wire flash_write_permit_i,
   input wire pwrup_timer_enable_i,
   input wire full_erase_i,
   // core instruction slot strobe
   input wire instr_slot_i,
   // flash array write port
   output reg flash_write_o,
   output reg [ADDR_WIDTH-1:0] flash_addr_o,
   output reg [13:0] flash_data_o,
   // core control and protection outputs
   output reg core_stall_o,
   output reg nvm_done_flag_o,
   output reg serial_port_disable_o
);
   localparam ST_IDLE = 2'h0;
   localparam ST_SETUP = 2'h1;
   localparam ST_WRITE = 2'h2;
   localparam [15:0] WRITE_COUNT = WRITE_CYCLES;
   localparam [15:0] PWRUP_COUNT = PWRUP_CYCLES;

   // register state
   reg [1:0] state_reg;
   reg program_memory_select_reg;
   reg program_arm_enable_reg;
   reg start_reg;
   reg nvm_abort_flag_reg;
   reg [1:0] unlock_reg;
   reg [1:0] slot_count_reg;
   reg [7:0] nvm_addr_low_reg;
   reg [7:0] nvm_addr_high_reg;
   reg [7:0] nvm_data_low_reg;
   reg [5:0] nvm_data_high_reg;
   reg [2:0] protect_reg;
   reg [15:0] pwrup_count_reg;
   reg power_seen_reg;
   wire permit_sync;
   wire pwrup_en_sync;
   wire erase_sync;
   wire timer_expired;
   wire [15:0] addr_full;
   wire timer_load;
   wire busy;
   wire write_control;
   wire write_unlock;
   wire start_request;
   wire start_ok;
   wire write_blocked;

   // configuration pin inputs pass two flops
   fsws_sync #(.WIDTH(3)) u_sync
   (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .enable_i(clock_enable_i),
      .async_i({flash_write_permit_i, pwrup_timer_enable_i, full_erase_i}),
      .sync_o({permit_sync, pwrup_en_sync, erase_sync})
   );

   // programming cycle timer
   fsws_timer #(.WIDTH(16)) u_timer
   (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .enable_i(clock_enable_i),
      .load_i(timer_load),
      .count_i(WRITE_COUNT),
      .expired_o(timer_expired),
      .running_o()
   );

   // decode of register accesses
   assign write_control = reg_write_i && (reg_addr_i == `FSWS_ADDR_CONTROL);
   assign write_unlock = reg_write_i && (reg_addr_i == `FSWS_ADDR_UNLOCK);
   assign addr_full = {nvm_addr_high_reg, nvm_addr_low_reg};
   assign busy = (state_reg != ST_IDLE);
   assign start_request = write_control && reg_wdata_i[`FSWS_CTL_START] && !busy;
   // writes blocked by permit pin or running power-up timer
   assign write_blocked = !permit_sync || (pwrup_count_reg != 16'h0000);
   // start needs arm from an earlier write, full unlock, program select
   assign start_ok = start_request && program_arm_enable_reg && (unlock_reg == 2'h2)
      && program_memory_select_reg && !write_blocked;
   assign timer_load = (state_reg == ST_SETUP) && (slot_count_reg == `FSWS_SETUP_SLOTS)
      && clock_enable_i;

   // power-up timer runs once after power-on reset
   always @(posedge clock_i)
   begin
      if (reset_i)
      begin
         pwrup_count_reg <= 16'h0000;
         power_seen_reg <= 1'b0;
      end
      else if (clock_enable_i)
      begin
         power_seen_reg <= 1'b1;
         if (!power_seen_reg && power_on_i && pwrup_en_sync)
            pwrup_count_reg <= PWRUP_COUNT;
         else if (pwrup_count_reg != 16'h0000)
            pwrup_count_reg <= pwrup_count_reg - 16'h0001;
      end
   end

   // unlock tracker: 55h then aah, any other access breaks it
   always @(posedge clock_i)
   begin
      if (reset_i)
         unlock_reg <= 2'h0;
      else if (clock_enable_i)
      begin
         if (write_unlock && reg_wdata_i == `FSWS_KEY_FIRST)
            unlock_reg <= 2'h1;
         else if (write_unlock && reg_wdata_i == `FSWS_KEY_SECOND && unlock_reg == 2'h1)
            unlock_reg <= 2'h2;
         else if (reg_write_i || reg_read_i)
            unlock_reg <= 2'h0;
      end
   end

   // control bits and sequencer
   always @(posedge clock_i)
   begin
      if (reset_i)
      begin
         state_reg <= ST_IDLE;
         program_memory_select_reg <= 1'b0;
         program_arm_enable_reg <= 1'b0;
         start_reg <= 1'b0;
         slot_count_reg <= 2'h0;
      end
      else if (clock_enable_i)
      begin
         if (write_control)
         begin
            program_arm_enable_reg <= reg_wdata_i[`FSWS_CTL_ARM];
            if (!busy)
               program_memory_select_reg <= reg_wdata_i[`FSWS_CTL_SELECT];
         end
         case (state_reg)
            ST_IDLE:
            begin
               slot_count_reg <= 2'h0;
               if (start_ok)
               begin
                  start_reg <= 1'b1;
                  state_reg <= ST_SETUP;
               end
            end
            ST_SETUP:
            begin
               // two no-op slots run before the stall
               if (instr_slot_i && slot_count_reg != `FSWS_SETUP_SLOTS)
                  slot_count_reg <= slot_count_reg + 2'h1;
               if (slot_count_reg == `FSWS_SETUP_SLOTS)
                  state_reg <= ST_WRITE;
            end
            ST_WRITE:
            begin
               if (timer_expired && !timer_load)
               begin
                  start_reg <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // abort flag: set when a master or watchdog reset lands mid-write and held
   // through the rest of that reset; a power-on reset or a clean finish clears it
   always @(posedge clock_i)
   begin
      if (reset_i)
      begin
         if (abort_reset_i && busy)
            nvm_abort_flag_reg <= 1'b1;
         else if (!abort_reset_i)
            nvm_abort_flag_reg <= 1'b0;
      end
      else if (clock_enable_i && state_reg == ST_WRITE && timer_expired)
         nvm_abort_flag_reg <= 1'b0;
   end

   // address and data holding registers
   always @(posedge clock_i)
   begin
      if (reset_i)
      begin
         nvm_addr_low_reg <= 8'h00;
         nvm_addr_high_reg <= 8'h00;
         nvm_data_low_reg <= 8'h00;
         nvm_data_high_reg <= 6'h00;
      end
      else if (clock_enable_i && reg_write_i && !busy)
      begin
         case (reg_addr_i)
            `FSWS_ADDR_ADDR_LOW: nvm_addr_low_reg <= reg_wdata_i;
            `FSWS_ADDR_ADDR_HIGH: nvm_addr_high_reg <= reg_wdata_i;
            `FSWS_ADDR_DATA_LOW: nvm_data_low_reg <= reg_wdata_i;
            `FSWS_ADDR_DATA_HIGH: nvm_data_high_reg <= reg_wdata_i[5:0];
            default: nvm_addr_low_reg <= nvm_addr_low_reg;
         endcase
      end
   end

   // sticky protection bits: set by software, cleared by full erase or reset
   always @(posedge clock_i)
   begin
      if (reset_i)
         protect_reg <= 3'h0;
      else if (clock_enable_i)
      begin
         if (erase_sync)
            protect_reg <= 3'h0;
         else if (reg_write_i && reg_addr_i == `FSWS_ADDR_CONFIG)
            protect_reg <= protect_reg | reg_wdata_i[2:0];
      end
   end

   // done flag: set wins over a same-cycle clear
   always @(posedge clock_i)
   begin
      if (reset_i)
         nvm_done_flag_o <= 1'b0;
      else if (clock_enable_i)
      begin
         if (state_reg == ST_WRITE && timer_expired)
            nvm_done_flag_o <= 1'b1;
         else if (reg_write_i && reg_addr_i == `FSWS_ADDR_STATUS && reg_wdata_i[`FSWS_STA_DONE])
            nvm_done_flag_o <= 1'b0;
      end
   end

   // outputs to core and flash array; no read-back compare follows
   always @(posedge clock_i)
   begin
      if (reset_i)
      begin
         core_stall_o <= 1'b0;
         flash_write_o <= 1'b0;
         flash_addr_o <= {ADDR_WIDTH{1'b0}};
         flash_data_o <= 14'h0000;
         serial_port_disable_o <= 1'b0;
      end
      else if (clock_enable_i)
      begin
         // stall only the core; clocks and interrupts untouched
         // stall starts with the program pulse so it spans the whole write time
         core_stall_o <= (timer_load || state_reg == ST_WRITE) && !(timer_expired && !timer_load);
         flash_write_o <= timer_load;
         if (timer_load)
         begin
            flash_addr_o <= addr_full[ADDR_WIDTH-1:0]; // low bits carry the word address
            flash_data_o <= {nvm_data_high_reg, nvm_data_low_reg};
         end
         // data protect bit clear plus any protection kills external access
         serial_port_disable_o <= !protect_reg[`FSWS_CFG_DPROT] && (protect_reg[1:0] != 2'h0);
      end
   end

   // register read data, one cycle after the strobe; reads never gated by protection
   always @(posedge clock_i)
   begin
      if (reset_i)
         reg_rdata_o <= 8'h00;
      else if (clock_enable_i)
      begin
         if (!reg_read_i)
            reg_rdata_o <= 8'h00;
         else
         begin
            case (reg_addr_i)
               `FSWS_ADDR_CONTROL: reg_rdata_o <= {program_memory_select_reg, 3'h0, nvm_abort_flag_reg,
                  program_arm_enable_reg, start_reg, 1'b0};
               `FSWS_ADDR_ADDR_LOW: reg_rdata_o <= nvm_addr_low_reg;
               `FSWS_ADDR_ADDR_HIGH: reg_rdata_o <= nvm_addr_high_reg;
               `FSWS_ADDR_DATA_LOW: reg_rdata_o <= nvm_data_low_reg;
               `FSWS_ADDR_DATA_HIGH: reg_rdata_o <= {2'h0, nvm_data_high_reg};
               `FSWS_ADDR_STATUS: reg_rdata_o <= {5'h00, core_stall_o, busy, nvm_done_flag_o};
               `FSWS_ADDR_CONFIG: reg_rdata_o <= {5'h00, protect_reg};
               default: reg_rdata_o <= 8'h00;
            endcase
         end
      end
   end
endmodule

/* logic/fsws_defines.vh */
// constants for the flash self-write sequencer
`ifndef FSWS_DEFINES_VH
`define FSWS_DEFINES_VH
// register addresses on the plain port
`define FSWS_ADDR_CONTROL 4'h0
`define FSWS_ADDR_UNLOCK 4'h1
`define FSWS_ADDR_ADDR_LOW 4'h2
`define FSWS_ADDR_ADDR_HIGH 4'h3
`define FSWS_ADDR_DATA_LOW 4'h4
`define FSWS_ADDR_DATA_HIGH 4'h5
`define FSWS_ADDR_STATUS 4'h6
`define FSWS_ADDR_CONFIG 4'h7
// control register fields
`define FSWS_CTL_SELECT 7
`define FSWS_CTL_ABORT 3
`define FSWS_CTL_ARM 2
`define FSWS_CTL_START 1
`define FSWS_CTL_READ 0
// status register fields
`define FSWS_STA_DONE 0
`define FSWS_STA_BUSY 1
`define FSWS_STA_STALL 2
// config register fields (sticky protection)
`define FSWS_CFG_CP0 0
`define FSWS_CFG_CP1 1
`define FSWS_CFG_DPROT 2
// unlock key values
`define FSWS_KEY_FIRST 8'h55
`define FSWS_KEY_SECOND 8'haa
// timing: write time in microseconds, clock in MHz
`define FSWS_WRITE_TIME_US 8
`define FSWS_CLOCK_MHZ 40
`define FSWS_WRITE_CYCLES (`FSWS_WRITE_TIME_US * `FSWS_CLOCK_MHZ)
`define FSWS_SETUP_SLOTS 2
// power-up block time
`define FSWS_PWRUP_TIME_US 72
`define FSWS_PWRUP_CYCLES (`FSWS_PWRUP_TIME_US * `FSWS_CLOCK_MHZ)
`endif

/* logic/fsws_sync.v */
// two-flop synchroniser for pin level inputs
`timescale 1ns/1ps
module fsws_sync
#(
   parameter WIDTH = 1
)
(
   input wire clock_i,
   input wire reset_i,
   input wire enable_i,
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);
   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;
   // first stage feeds only the second; pin levels keep flowing through reset
   // so that they are already settled on the first cycle after release
   always @(posedge clock_i)
   begin
      if (reset_i || enable_i)
      begin
         stage1_reg <= async_i;
         stage2_reg <= stage1_reg;
      end
   end
   assign sync_o = stage2_reg;
endmodule

/* logic/fsws_timer.v */
// down counter that times one programming cycle
`timescale 1ns/1ps
module fsws_timer
#(
   parameter WIDTH = 16
)
(
   input wire clock_i,
   input wire reset_i,
   input wire enable_i,
   input wire load_i,
   input wire [WIDTH-1:0] count_i,
   output wire expired_o,
   output wire running_o
);
   reg [WIDTH-1:0] count_reg;
   // load, then count down to zero
   always @(posedge clock_i)
   begin
      if (reset_i)
         count_reg <= {WIDTH{1'b0}};
      else if (enable_i)
      begin
         if (load_i)
            count_reg <= count_i;
         else if (count_reg != {WIDTH{1'b0}})
            count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
   assign running_o = (count_reg != {WIDTH{1'b0}});
   assign expired_o = (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule

/* verification/fsws_top_props.sv */
// assertions on the flash self-write sequencer ports
`timescale 1ns/1ps
`include "fsws_defines.vh"
module fsws_top_props
#(
   parameter ADDR_WIDTH = 13,
   parameter WRITE_CYCLES = 8
)
(
   // clock and control inputs
   input wire clock_i,
   input wire reset_i,
   input wire clock_enable_i,
   input wire [3:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_write_i,
   input wire reg_read_i,
   input wire power_on_i,
   input wire abort_reset_i,
   input wire flash_write_permit_i,
   input wire pwrup_timer_enable_i,
   input wire full_erase_i,
   input wire instr_slot_i,
   // design outputs
   input wire [7:0] reg_rdata_o,
   input wire flash_write_o,
   input wire [ADDR_WIDTH-1:0] flash_addr_o,
   input wire [13:0] flash_data_o,
   input wire core_stall_o,
   input wire nvm_done_flag_o,
   input wire serial_port_disable_o
);
   int unsigned run_n;
   int unsigned slot_n;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   // stall run length and slots since the last control write
   always @(posedge clock_i)
   begin
      run_n <= (reset_i || !core_stall_o) ? 0 : run_n + 1;
      if (reset_i || (reg_write_i && reg_addr_i == `FSWS_ADDR_CONTROL))
         slot_n <= 0;
      else if (instr_slot_i && slot_n < 3)
         slot_n <= slot_n + 1;
   end
   AST_PULSE_STALL: assert property (flash_write_o |=> core_stall_o [*2])
      else $error("core not stalled after program pulse");
   AST_STALL_LEN: assert property ($fell(core_stall_o) |-> run_n == WRITE_CYCLES)
      else $error("stall length differs from write time");
   AST_DONE_AT_END: assert property ($fell(core_stall_o) |-> ##[0:1] nvm_done_flag_o)
      else $error("done flag not raised at end of write");
   AST_DONE_STICKY: assert property (nvm_done_flag_o && !(reg_write_i && reg_addr_i == `FSWS_ADDR_STATUS
      && reg_wdata_i[`FSWS_STA_DONE]) |=> nvm_done_flag_o) else $error("done flag dropped by itself");
   AST_PERMIT_BLOCK: assert property (!flash_write_permit_i [*8] |-> !flash_write_o)
      else $error("program pulse while write permit low");
   AST_ADDR_HOLD: assert property (core_stall_o && $past(core_stall_o) |-> $stable(flash_addr_o))
      else $error("address moved during write");
   AST_SINGLE_PULSE: assert property (flash_write_o |=> !flash_write_o [*8])
      else $error("second program pulse within one write");
   AST_SLOTS: assert property (flash_write_o |-> slot_n >= 2)
      else $error("program pulse before two setup slots");
   // main scenarios reached
   cover property (flash_write_o);
   cover property ($fell(core_stall_o));
   cover property (nvm_done_flag_o && reg_write_i);
endmodule

/* verification/fsws_top_test.sv */
// self-checking bench for the flash self-write sequencer
`timescale 1ns/1ps
`include "fsws_defines.vh"
module fsws_top_test;
   localparam WC = 8;
   localparam PC = 40;
   reg clock_i = 1'b0;
   reg reset_i = 1'b1;
   reg clock_enable_i = 1'b1;
   reg [3:0] reg_addr_i = 4'h0;
   reg [7:0] reg_wdata_i = 8'h00;
   reg reg_write_i = 1'b0;
   reg reg_read_i = 1'b0;
   reg power_on_i = 1'b1;
   reg abort_reset_i = 1'b0;
   reg flash_write_permit_i = 1'b1;
   reg pwrup_timer_enable_i = 1'b1;
   reg full_erase_i = 1'b0;
   reg instr_slot_i = 1'b0;
   wire [7:0] reg_rdata_o;
   wire flash_write_o;
   wire [12:0] flash_addr_o;
   wire [13:0] flash_data_o;
   wire core_stall_o;
   wire nvm_done_flag_o;
   wire serial_port_disable_o;
   int n_fail = 0;
   int total_checks = 0;
   int n_wr = 0;
   int i;
   reg [12:0] a_cap = 13'h0000;
   reg [13:0] d_cap = 14'h0000;
   reg [7:0] rv;
   fsws_top #(.ADDR_WIDTH(13), .WRITE_CYCLES(WC), .PWRUP_CYCLES(PC)) u_fsws_top (.*);
   // 40 MHz clock
   always #12.5 clock_i = ~clock_i;
   // count program pulses and keep their address and data
   always @(posedge clock_i)
   begin
      if (flash_write_o === 1'b1)
      begin
         n_wr <= n_wr + 1;
         a_cap <= flash_addr_o;
         d_cap <= flash_data_o;
      end
   end
   task chk(input string nm, input [15:0] seen, input [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge clock_i);
      reg_write_i <= 1'b0;
   endtask
   task rd(input [3:0] a);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clock_i);
      reg_read_i <= 1'b0;
      #1 rv = reg_rdata_o;
   endtask
   // arm, unlock, start, two setup slots, then wait for a pulse
   task go(input [7:0] c1, input [7:0] k2);
      wr(`FSWS_ADDR_CONTROL, c1);
      wr(`FSWS_ADDR_UNLOCK, `FSWS_KEY_FIRST);
      wr(`FSWS_ADDR_UNLOCK, k2);
      wr(`FSWS_ADDR_CONTROL, 8'h86);
      repeat (2)
      begin
         @(posedge clock_i);
         instr_slot_i <= 1'b1;
         @(posedge clock_i);
         instr_slot_i <= 1'b0;
      end
      for (i = 0; i < 12 && flash_write_o !== 1'b1; i++)
      begin
         @(posedge clock_i);
         #1;
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog against a hang
   initial
   begin
      #(25 * 5000);
      n_fail++;
      complete_run;
   end
   // test sequence
   initial
   begin
      repeat (12) @(posedge clock_i);
      reset_i <= 1'b0;
      rd(`FSWS_ADDR_CONTROL);
      chk("arm", rv[2], 1'b0);
      go(8'h84, `FSWS_KEY_SECOND);
      chk("writes", n_wr[15:0], 16'd0);
      $display("end power_up_block");
      repeat (PC) @(posedge clock_i);
      go(8'h80, `FSWS_KEY_SECOND);
      chk("writes", n_wr[15:0], 16'd0);
      $display("end same_op_start");
      wr(`FSWS_ADDR_ADDR_LOW, 8'h34);
      wr(`FSWS_ADDR_ADDR_HIGH, 8'h12);
      wr(`FSWS_ADDR_DATA_LOW, 8'ha5);
      wr(`FSWS_ADDR_DATA_HIGH, 8'h3c);
      go(8'h84, `FSWS_KEY_SECOND);
      // disarm and try to clear select and start mid-write
      wr(`FSWS_ADDR_CONTROL, 8'h00);
      for (i = 0; i < 30 && nvm_done_flag_o !== 1'b1; i++)
      begin
         @(posedge clock_i);
         #1;
      end
      chk("writes", n_wr[15:0], 16'd1);
      chk("addr", a_cap, 13'h1234);
      chk("data", d_cap, 14'h3ca5);
      rd(`FSWS_ADDR_CONTROL);
      chk("control", rv, 8'h80);
      chk("stall", core_stall_o, 1'b0);
      repeat (5) @(posedge clock_i);
      rd(`FSWS_ADDR_STATUS);
      chk("status", rv, 8'h01);
      wr(`FSWS_ADDR_STATUS, 8'h01);
      rd(`FSWS_ADDR_STATUS);
      chk("status", rv, 8'h00);
      $display("end full_write");
      go(8'h84, 8'h12);
      chk("writes", n_wr[15:0], 16'd1);
      $display("end broken_unlock");
      flash_write_permit_i <= 1'b0;
      repeat (8) @(posedge clock_i);
      go(8'h84, `FSWS_KEY_SECOND);
      chk("writes", n_wr[15:0], 16'd1);
      flash_write_permit_i <= 1'b1;
      $display("end permit_low");
      repeat (4) @(posedge clock_i);
      go(8'h84, `FSWS_KEY_SECOND);
      // watchdog-style reset in mid-write
      @(posedge clock_i);
      reset_i <= 1'b1;
      abort_reset_i <= 1'b1;
      power_on_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      abort_reset_i <= 1'b0;
      rd(`FSWS_ADDR_CONTROL);
      chk("writes", n_wr[15:0], 16'd2);
      chk("abort", rv & 8'h0e, 8'h08);
      $display("end abort_reset");
      wr(`FSWS_ADDR_ADDR_LOW, 8'h5a);
      wr(`FSWS_ADDR_DATA_LOW, 8'hc3);
      wr(`FSWS_ADDR_CONFIG, 8'h01);
      rd(`FSWS_ADDR_CONFIG);
      chk("protect", rv[0], 1'b1);
      chk("serial", serial_port_disable_o, 1'b1);
      rd(`FSWS_ADDR_ADDR_LOW);
      chk("addr_low", rv, 8'h5a);
      wr(`FSWS_ADDR_CONFIG, 8'h04);
      rd(`FSWS_ADDR_DATA_LOW);
      chk("data_low", rv, 8'hc3);
      chk("serial", serial_port_disable_o, 1'b0);
      full_erase_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      full_erase_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      rd(`FSWS_ADDR_CONFIG);
      chk("protect", rv[0], 1'b0);
      $display("end full_erase");
      complete_run;
   end
endmodule
bind fsws_top fsws_top_props #(.ADDR_WIDTH(ADDR_WIDTH), .WRITE_CYCLES(WRITE_CYCLES)) u_fsws_top_props (.*);
